// ===== rtl/tcio_defs.vh
// What this block does
// - Top field bit: 0 compare, 1 capture
// - Hold codes keep pin; low after reset
// - Low bits 01: drive low on match
// - Low bits 10: drive high on match
// - Low bits 11: toggle pin on match
// - 1000 rising edge, 1001 falling edge capture
// - 101X captures on both pin edges
// - B field 11XX: capture on channel 0 C event
// - A field 11XX: capture on channel 0 A event
// - Buffer mode on: ignore channel 0 C events
`ifndef TCIO_DEFS_VH
`define TCIO_DEFS_VH

// Register word indices on the plain port
`define TCIO_ADDR_W 4
`define TCIO_DATA_W 16
`define TCIO_OFF_CTRL 4'h0
`define TCIO_OFF_GRA 4'h1
`define TCIO_OFF_GRB 4'h2
`define TCIO_OFF_PINS 4'h3
`define TCIO_OFF_FLAGS 4'h4

// Control register layout and reset value
`define TCIO_CTRL_W 8
`define TCIO_CTRL_RST 8'h00
`define TCIO_B_HI 7
`define TCIO_B_LO 4
`define TCIO_A_HI 3
`define TCIO_A_LO 0

// Bits inside one 4-bit selection field
`define TCIO_SEL_CAPT 3
`define TCIO_SEL_LVL 2
`define TCIO_ACT_HOLD 2'h0
`define TCIO_ACT_LOW 2'h1
`define TCIO_ACT_HIGH 2'h2
`define TCIO_ACT_TOG 2'h3

// Event flag bit positions
`define TCIO_FLG_A_MATCH 0
`define TCIO_FLG_A_CAPT 1
`define TCIO_FLG_B_MATCH 2
`define TCIO_FLG_B_CAPT 3
`define TCIO_FLG_W 4

// General register reset value
`define TCIO_GR_RST 16'hFFFF

`endif

// ===== rtl/tcio_pin.v
`include "tcio_defs.vh"

// Pin side of one general register: output action and capture trigger
module tcio_pin (
  // Clock and reset
  input wire sys_clk,
  input wire rstn,
  // Selection field and its load strobe
  input wire [3:0] sel,
  input wire sel_load,
  // Compare match and cascaded trigger
  input wire match,
  input wire cascade_evt,
  // Two-way pin
  input wire pin_in,
  output reg pin_out,
  output reg pin_oe,
  // Capture trigger pulse
  output reg trig
);

  // Previous pin sample for edge detection
  reg pin_q;
  // Edge terms
  wire rise;
  wire fall;

  assign rise = pin_in & ~pin_q;
  assign fall = ~pin_in & pin_q;

  // Pin sample history; inputs are already synchronous
  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      pin_q <= 1'b0;
    else
      pin_q <= pin_in;
  end

  // Capture trigger select, only in capture mode
  always @*
  begin
    trig = 1'b0;
    if (sel[`TCIO_SEL_CAPT])
    begin
      // Capture mode
      casez (sel[2:0])
        3'b000: trig = rise;
        3'b001: trig = fall;
        3'b01?: trig = rise | fall;
        3'b1??: trig = cascade_evt;
        default: trig = 1'b0;
      endcase
    end
  end

  // Output driver; reset drives low so the pin reads low until configured
  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pin_out <= 1'b0;
      pin_oe <= 1'b1;
    end
    else
    begin
      // Drive only while the register acts for compare
      pin_oe <= ~sel[`TCIO_SEL_CAPT];
      if (sel_load && !sel[`TCIO_SEL_CAPT] && sel[1:0] != `TCIO_ACT_HOLD)
      begin
        // A fresh code wins over a match in the same cycle
        pin_out <= sel[`TCIO_SEL_LVL];
      end
      else if (match && !sel[`TCIO_SEL_CAPT])
      begin
        // Compare match action
        case (sel[1:0])
          `TCIO_ACT_HOLD: pin_out <= pin_out;
          `TCIO_ACT_LOW: pin_out <= 1'b0;
          `TCIO_ACT_HIGH: pin_out <= 1'b1;
          `TCIO_ACT_TOG: pin_out <= ~pin_out;
          default: pin_out <= pin_out;
        endcase
      end
    end
  end

endmodule

// ===== rtl/tcio_top.v
`include "tcio_defs.vh"

// Channel 1 pin and general register function control
module tcio_top (
  // Clock and reset
  input wire sys_clk,
  input wire rstn,
  // Register port
  input wire [`TCIO_ADDR_W-1:0] reg_addr,
  input wire [`TCIO_DATA_W-1:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [`TCIO_DATA_W-1:0] reg_rdata,
  // Counter from the timer core
  input wire [15:0] count_value,
  input wire count_tick,
  // Channel 0 cascade inputs
  input wire ch0_reg_a_evt,
  input wire ch0_reg_c_evt,
  input wire buffer_a_mode_bit,
  // Pin A
  input wire ch1_pin_a_in,
  output wire ch1_pin_a_out,
  output wire ch1_pin_a_oe,
  // Pin B
  input wire ch1_pin_b_in,
  output wire ch1_pin_b_out,
  output wire ch1_pin_b_oe,
  // Event pulses towards the timer core
  output reg a_match_evt,
  output reg a_capture_evt,
  output reg b_match_evt,
  output reg b_capture_evt
);

  // Control register holding both selection fields
  reg [`TCIO_CTRL_W-1:0] ch1_pin_function_control;
  // General registers
  reg [15:0] ch1_general_reg_a;
  reg [15:0] ch1_general_reg_b;
  // Sticky event flags, write one to clear
  reg [`TCIO_FLG_W-1:0] ev_flags;
  reg [`TCIO_FLG_W-1:0] next_ev_flags;

  // Field views
  wire [3:0] a_sel;
  wire [3:0] b_sel;
  // Control write strobe
  wire ctrl_wr;
  // Write strobe delayed one edge, so the pin units see the new field
  reg ctrl_load;
  // Compare match terms
  wire a_match;
  wire b_match;
  // Capture triggers from the pin units
  wire a_trig;
  wire b_trig;
  // Cascade source for B after gating
  wire b_cascade;
  // Read mux result
  reg [`TCIO_DATA_W-1:0] next_rdata;

  // Field split of the control register
  assign b_sel = ch1_pin_function_control[`TCIO_B_HI:`TCIO_B_LO];
  assign a_sel = ch1_pin_function_control[`TCIO_A_HI:`TCIO_A_LO];

  assign ctrl_wr = reg_wr && (reg_addr == `TCIO_OFF_CTRL);

  // True when a field selects input capture
  function is_capture;
    input [3:0] sel;
    begin
      is_capture = sel[`TCIO_SEL_CAPT];
    end
  endfunction

  // Compare match while the register acts for compare
  function compare_hit;
    input tick;
    input [3:0] sel;
    input [15:0] cnt;
    input [15:0] gr;
    begin
      compare_hit = tick && !is_capture(sel) && (cnt == gr);
    end
  endfunction

  // Compare matches only on counter steps, so a static equal counter
  // does not fire every cycle
  assign a_match = compare_hit(count_tick, a_sel, count_value, ch1_general_reg_a);
  assign b_match = compare_hit(count_tick, b_sel, count_value, ch1_general_reg_b);

  // Register C of channel 0 is a buffer in buffer mode and raises no events
  assign b_cascade = ch0_reg_c_evt & ~buffer_a_mode_bit;

  // Pin unit for general register A
  tcio_pin u_pin_a (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .sel(a_sel),
    .sel_load(ctrl_load),
    .match(a_match),
    .cascade_evt(ch0_reg_a_evt),
    .pin_in(ch1_pin_a_in),
    .pin_out(ch1_pin_a_out),
    .pin_oe(ch1_pin_a_oe),
    .trig(a_trig)
  );

  // Pin unit for general register B
  tcio_pin u_pin_b (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .sel(b_sel),
    .sel_load(ctrl_load),
    .match(b_match),
    .cascade_evt(b_cascade),
    .pin_in(ch1_pin_b_in),
    .pin_out(ch1_pin_b_out),
    .pin_oe(ch1_pin_b_oe),
    .trig(b_trig)
  );

  // Control register; the pin units see the new field right after the write edge,
  // in the same cycle as the load strobe, which ctrl_load delays by one edge
  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      ch1_pin_function_control <= `TCIO_CTRL_RST;
    else if (ctrl_wr)
      ch1_pin_function_control <= reg_wdata[`TCIO_CTRL_W-1:0];
  end

  // Load strobe for the pin units; the field is registered at the write
  // edge, so the initial level must be applied one edge later
  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      ctrl_load <= 1'b0;
    else
      ctrl_load <= ctrl_wr;
  end

  // General register A: capture beats a software write in the same cycle
  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      ch1_general_reg_a <= `TCIO_GR_RST;
    else if (a_trig)
    begin
      // Counter snapshot
      ch1_general_reg_a <= count_value;
    end
    else if (reg_wr && reg_addr == `TCIO_OFF_GRA)
    begin
      // Software compare value
      ch1_general_reg_a <= reg_wdata;
    end
  end

  // General register B, same priority as A
  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      ch1_general_reg_b <= `TCIO_GR_RST;
    else if (b_trig)
    begin
      // Counter snapshot
      ch1_general_reg_b <= count_value;
    end
    else if (reg_wr && reg_addr == `TCIO_OFF_GRB)
    begin
      // Software compare value
      ch1_general_reg_b <= reg_wdata;
    end
  end

  // Flag update: clear by writing one, a new event in that cycle wins
  always @*
  begin
    next_ev_flags = ev_flags;
    if (reg_wr && reg_addr == `TCIO_OFF_FLAGS)
    begin
      // Clear selected flags
      next_ev_flags = ev_flags & ~reg_wdata[`TCIO_FLG_W-1:0];
    end
    // Hardware sets last so they override the clear
    if (a_match)
      next_ev_flags[`TCIO_FLG_A_MATCH] = 1'b1;
    if (a_trig)
      next_ev_flags[`TCIO_FLG_A_CAPT] = 1'b1;
    if (b_match)
      next_ev_flags[`TCIO_FLG_B_MATCH] = 1'b1;
    if (b_trig)
      next_ev_flags[`TCIO_FLG_B_CAPT] = 1'b1;
  end

  // Flag storage
  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      ev_flags <= {`TCIO_FLG_W{1'b0}};
    else
      ev_flags <= next_ev_flags;
  end

  // Event pulses, one cycle after the cause
  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      a_match_evt <= 1'b0;
      a_capture_evt <= 1'b0;
      b_match_evt <= 1'b0;
      b_capture_evt <= 1'b0;
    end
    else
    begin
      a_match_evt <= a_match;
      a_capture_evt <= a_trig;
      b_match_evt <= b_match;
      b_capture_evt <= b_trig;
    end
  end

  // Read mux; unmapped words read as zero
  always @*
  begin
    next_rdata = {`TCIO_DATA_W{1'b0}};
    case (reg_addr)
      `TCIO_OFF_CTRL:
        next_rdata = {8'h00, ch1_pin_function_control};
      `TCIO_OFF_GRA:
        next_rdata = ch1_general_reg_a;
      `TCIO_OFF_GRB:
        next_rdata = ch1_general_reg_b;
      `TCIO_OFF_PINS:
        next_rdata = {10'h000, ch1_pin_b_oe, ch1_pin_b_out, ch1_pin_b_in,
                      ch1_pin_a_oe, ch1_pin_a_out, ch1_pin_a_in};
      `TCIO_OFF_FLAGS:
        next_rdata = {12'h000, ev_flags};
      default:
        next_rdata = {`TCIO_DATA_W{1'b0}};
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      reg_rdata <= {`TCIO_DATA_W{1'b0}};
    else if (reg_rd)
      reg_rdata <= next_rdata;
    else
      reg_rdata <= {`TCIO_DATA_W{1'b0}};
  end

endmodule

// ===== test/tb.sv
`include "tcio_defs.vh"

bind tcio_top tcio_chk i_chk (.*);

// Self-checking bench
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk, rstn, reg_wr, reg_rd, count_tick, a_lvl, b_lvl;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, count_value;
  logic ch0_reg_a_evt, ch0_reg_c_evt, buffer_a_mode_bit;
  wire [15:0] reg_rdata;
  wire ch1_pin_a_in, ch1_pin_a_out, ch1_pin_a_oe, ch1_pin_b_in, ch1_pin_b_out, ch1_pin_b_oe;
  wire a_match_evt, a_capture_evt, b_match_evt, b_capture_evt;
  int n_mismatch, compares;
  // Compare rows: A code, initial level, level after match
  logic [5:0] rows [8] = '{6'h04, 6'h09, 6'h0D, 6'h16, 6'h1E, 6'h1B, 6'h13, 6'h03};
  tcio_top i_dut (.*);
  tcio_ext i_ext (.*);
  initial
  begin
    sys_clk = 1'h0;
    forever #25 sys_clk = ~sys_clk;
  end
  task end_of_test;
    if (n_mismatch == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e)
    begin
      $display("BAD %s exp %h got %h", nm, e, g);
      n_mismatch++;
    end
  endtask
  // Strobe cleared on its own edge, so tasks may follow each other
  task wr(input logic [3:0] a, input logic [15:0] d);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'h0;
    @(posedge sys_clk);
  endtask
  task rd(input logic [3:0] a, input logic [15:0] e);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'h0;
    @(negedge sys_clk);
    chk("rdata", e, reg_rdata);
    @(posedge sys_clk);
  endtask
  // Pin edge l0 to l1 under code c; when e is set, GR must then hold the count
  task cap(input logic [7:0] c, input logic b, l0, l1, e);
    if (b) b_lvl <= l0; else a_lvl <= l0;
    count_value <= {c, 8'h5A};
    wr(`TCIO_OFF_CTRL, {8'h00, c});
    @(posedge sys_clk);
    if (b) b_lvl <= l1; else a_lvl <= l1;
    @(posedge sys_clk);
    @(negedge sys_clk);
    chk("capture", e, b ? b_capture_evt : a_capture_evt);
    @(posedge sys_clk);
    if (e) rd(b ? `TCIO_OFF_GRB : `TCIO_OFF_GRA, {c, 8'h5A});
  endtask
  task casc(input logic cv, av, bf, ea, eb);
    ch0_reg_c_evt <= cv;
    ch0_reg_a_evt <= av;
    buffer_a_mode_bit <= bf;
    @(posedge sys_clk);
    ch0_reg_c_evt <= 1'h0;
    ch0_reg_a_evt <= 1'h0;
    @(negedge sys_clk);
    chk("a_capt", ea, a_capture_evt);
    chk("b_capt", eb, b_capture_evt);
    @(posedge sys_clk);
  endtask
  // Watchdog, far beyond the roughly 130 cycles needed
  initial
  begin
    repeat (3000) @(posedge sys_clk);
    n_mismatch++;
    end_of_test;
  end
  initial
  begin
    {rstn, reg_wr, reg_rd, count_tick, a_lvl, b_lvl} = 6'h00;
    {reg_addr, reg_wdata, count_value} = 36'h0;
    {ch0_reg_a_evt, ch0_reg_c_evt, buffer_a_mode_bit} = 3'h0;
    repeat (3) @(posedge sys_clk);
    rstn <= 1'h1;
    @(negedge sys_clk);
    chk("pin_a", 16'h0000, ch1_pin_a_out);
    chk("oe_a", 16'h0001, ch1_pin_a_oe);
    chk("pin_b", 16'h0000, ch1_pin_b_out);
    @(posedge sys_clk);
    rd(`TCIO_OFF_CTRL, 16'h0000);
    wr(`TCIO_OFF_GRA, 16'h1234);
    for (int i = 0; i < 8; i++)
    begin
      wr(`TCIO_OFF_CTRL, {12'h000, rows[i][5:2]});
      @(negedge sys_clk);
      chk("init", rows[i][1], ch1_pin_a_out);
      @(posedge sys_clk);
      count_value <= 16'h1234;
      count_tick <= 1'h1;
      @(posedge sys_clk);
      count_tick <= 1'h0;
      count_value <= 16'h0000;
      @(negedge sys_clk);
      chk("match", 16'h0001, a_match_evt);
      chk("after", rows[i][0], ch1_pin_a_out);
      @(posedge sys_clk);
    end
    cap(8'h80, 1'h1, 1'h0, 1'h1, 1'h1);
    cap(8'h80, 1'h1, 1'h1, 1'h0, 1'h0);
    cap(8'h90, 1'h1, 1'h1, 1'h0, 1'h1);
    cap(8'hA0, 1'h1, 1'h0, 1'h1, 1'h1);
    cap(8'hB0, 1'h1, 1'h1, 1'h0, 1'h1);
    cap(8'h09, 1'h0, 1'h1, 1'h0, 1'h1);
    cap(8'h0B, 1'h0, 1'h0, 1'h1, 1'h1);
    cap(8'hC0, 1'h1, 1'h1, 1'h0, 1'h0);
    wr(`TCIO_OFF_CTRL, 16'h00CC);
    casc(1'h1, 1'h0, 1'h0, 1'h0, 1'h1);
    casc(1'h1, 1'h0, 1'h1, 1'h0, 1'h0);
    casc(1'h0, 1'h1, 1'h0, 1'h1, 1'h0);
    wr(`TCIO_OFF_GRB, 16'h0042);
    wr(`TCIO_OFF_CTRL, 16'h0030);
    @(negedge sys_clk);
    chk("init_b", 16'h0000, ch1_pin_b_out);
    chk("oe_b", 16'h0001, ch1_pin_b_oe);
    @(posedge sys_clk);
    count_value <= 16'h0042;
    count_tick <= 1'h1;
    @(posedge sys_clk);
    count_tick <= 1'h0;
    @(negedge sys_clk);
    chk("b_match", 16'h0001, b_match_evt);
    chk("a_match", 16'h0000, a_match_evt);
    chk("tog_b", 16'h0001, ch1_pin_b_out);
    @(posedge sys_clk);
    rd(`TCIO_OFF_FLAGS, 16'h000F);
    wr(`TCIO_OFF_FLAGS, 16'h000F);
    rd(`TCIO_OFF_FLAGS, 16'h0000);
    wr(`TCIO_OFF_CTRL, 16'hA55A);
    rd(`TCIO_OFF_CTRL, 16'h005A);
    rd(4'hF, 16'h0000);
    end_of_test;
  end
endmodule

// ===== test/tcio_chk.sv
`include "tcio_defs.vh"

// Port checker for the channel 1 pin control block
module tcio_chk (
  // Clock and reset
  input logic sys_clk,
  input logic rstn,
  // Register port
  input logic [`TCIO_ADDR_W-1:0] reg_addr,
  input logic [`TCIO_DATA_W-1:0] reg_wdata,
  input logic reg_wr,
  input logic reg_rd,
  input logic [`TCIO_DATA_W-1:0] reg_rdata,
  // Channel 0 cascade
  input logic ch0_reg_a_evt,
  input logic ch0_reg_c_evt,
  input logic buffer_a_mode_bit,
  // Pins and events
  input logic ch1_pin_a_in,
  input logic ch1_pin_a_out,
  input logic ch1_pin_b_in,
  input logic a_match_evt,
  input logic a_capture_evt,
  input logic b_capture_evt
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // Shadow of the control register, old field holds in the write cycle
  logic [7:0] ctl;
  always_ff @(posedge sys_clk or negedge rstn)
    if (!rstn)
      ctl <= 8'h00;
    else if (reg_wr && reg_addr == `TCIO_OFF_CTRL)
      ctl <= reg_wdata[7:0];
  a_rd_idle: assert property (
    !$past(reg_rd) |-> reg_rdata == 16'h0000) else $error("stray read data");
  a_init_lvl: assert property (
    reg_wr && reg_addr == `TCIO_OFF_CTRL && !reg_wdata[3] && reg_wdata[1:0] != 2'h0
    |=> ##1 ch1_pin_a_out == $past(reg_wdata[2], 2)) else $error("bad initial level");
  a_cmp_low: assert property (
    a_match_evt && $past(ctl[1:0]) == 2'h1 |-> !ch1_pin_a_out) else $error("no low");
  a_cmp_tog: assert property (
    a_match_evt && $past(ctl[1:0]) == 2'h3 |-> ch1_pin_a_out != $past(ch1_pin_a_out))
    else $error("no toggle");
  a_b_rise: assert property (
    ctl[7:4] == 4'h8 && $rose(ch1_pin_b_in) |=> b_capture_evt) else $error("no rise capture");
  a_a_fall: assert property (
    ctl[3:0] == 4'h9 && $fell(ch1_pin_a_in) |=> a_capture_evt) else $error("no fall capture");
  a_casc_b: assert property (
    ctl[7:6] == 2'h3 && ch0_reg_c_evt && !buffer_a_mode_bit |=> b_capture_evt)
    else $error("no cascade b");
  a_buf_ign: assert property (
    ctl[7:6] == 2'h3 && buffer_a_mode_bit |=> !b_capture_evt) else $error("buffer not ignored");
  a_casc_a: assert property (
    ctl[3:2] == 2'h3 && ch0_reg_a_evt |=> a_capture_evt) else $error("no cascade a");
  // Main scenarios reached
  c_match: cover property (a_match_evt);
  c_capa: cover property (a_capture_evt);
  c_capb: cover property (b_capture_evt);
endmodule

// ===== test/tcio_ext.sv
// Outside world on the two channel 1 pins
module tcio_ext (
  // Levels the outside drives
  input logic a_lvl,
  input logic b_lvl,
  // Device drive
  input logic ch1_pin_a_out,
  input logic ch1_pin_a_oe,
  input logic ch1_pin_b_out,
  input logic ch1_pin_b_oe,
  // Wire levels back to the device
  output logic ch1_pin_a_in,
  output logic ch1_pin_b_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // Device wins while it drives; outside level otherwise
  assign ch1_pin_a_in = ch1_pin_a_oe ? ch1_pin_a_out : a_lvl;
  assign ch1_pin_b_in = ch1_pin_b_oe ? ch1_pin_b_out : b_lvl;
endmodule
